// ---- hw/psl_defines.svh ----
// Constants for the transceiver status and LED control register block.
// Assumes an AXI4-Lite master with 32-bit data and one mclk domain.
//
// Contract
// (R1) Clearing link enable puts the device in standby, shown in status 15.
// (R2) Setting link enable again leaves standby and restarts auto-negotiation.
// (R3) Fault field 14:13 reads 10 master/slave, 01 parallel detect, 00 none.
// (R4) Status bit 12 is one once auto-negotiation has completed.
// (R5) Status bit 11 is one when pairs A and B are swapped.
// (R6) Status bit 10 shows inverted 10 Mb/s polarity and resets to one.
// (R7) Speed 11 undetermined at reset; bit 7 full duplex; bit 6 link up.
// (R8) Status bit 5 is one while a packet is transmitted.
// (R9) Status bit 4 is one while a packet is received.
// (R10) Status bit 3 is one while a collision occurs.
// (R11) Status bit 2 is one when both partners enable auto-negotiation.
// (R12) Status bit 1 shows partner symmetric pause advertisement.
// (R13) Status bit 0 shows partner asymmetric pause advertisement.
// (R14) Control bit 14 pairs link/activity and gigabit LEDs as two colours.
// (R15) A two-colour pair never lights both of its LEDs together.
// (R16) Control bit 15 pairs the hundred and ten LEDs likewise.
// (R17) Control bits 13 to 10 select extended modes, one LED each.
// (R18) The ten LED extended bit resets from the LED configuration strap.
// (R19) Bits 7:4 hold blink pause cycles, reset zero; bits 9:8 reserved.
// (R20) Status writes are ignored; status fields track hardware live.
`ifndef PSL_DEFINES_SVH
`define PSL_DEFINES_SVH

// ====================================================================
// Register indices; the byte address is four times the index.
`define PSL_IDX_LINK_CTL 8'h17
`define PSL_IDX_STATUS 8'h1A
`define PSL_IDX_LED_CTL 8'h1B
`define PSL_IDX_MSB 9
`define PSL_IDX_LSB 2
`define PSL_ADDR_MSB 11

// ====================================================================
// Field positions.
`define PSL_LINK_EN_BIT 13
`define PSL_TWO_CD_BIT 15
`define PSL_TWO_AB_BIT 14
`define PSL_EXT_MSB 13
`define PSL_EXT_LSB 10
`define PSL_EXT_TEN_BIT 13
`define PSL_BLINK_MSB 7
`define PSL_BLINK_LSB 4
`define PSL_FAULT_MSB 14
`define PSL_FAULT_LSB 13
`define PSL_SPEED_MSB 9
`define PSL_SPEED_LSB 8
`define PSL_POL_BIT 10

// ====================================================================
// Reset values and responses.
`define PSL_STATUS_RST 15'h0700
`define PSL_LINK_EN_RST 1'h1
`define PSL_STRAP_WAIT 3'h5
`define PSL_RESP_OKAY 2'h0
`define PSL_RESP_DECERR 2'h3

`endif

// ---- hw/psl_pkg.sv ----
// Types shared by the status and LED control register block.
// Assumes nothing of its surroundings.
package psl_pkg;

    // ================================================================
    // Link state and register selection.
    typedef enum logic [1:0] {
        PSL_LINK_STANDBY,
        PSL_LINK_NEGOTIATE,
        PSL_LINK_UP
    } psl_link_state_t;

    typedef enum logic [1:0] {
        PSL_SEL_NONE,
        PSL_SEL_LINK,
        PSL_SEL_STATUS,
        PSL_SEL_LED
    } psl_reg_sel_t;

endpackage

// ---- hw/psl_status_regs.sv ----
// Transceiver status register, link control and first LED control
// register behind an AXI4-Lite slave, plus two-colour LED pairing.
// Assumes status inputs are asynchronous and LED functions are on mclk.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "psl_defines.svh"
module psl_status_regs (
    // Clock and reset.
    input wire logic mclk,
    input wire logic sys_rst,
    // AXI4-Lite write address and data.
    input wire logic [`PSL_ADDR_MSB:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response.
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read.
    input wire logic [`PSL_ADDR_MSB:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Transceiver core status, asynchronous.
    input wire logic [1:0] anFaultCode,
    input wire logic anComplete,
    input wire logic pairSwapped,
    input wire logic polarityInverted,
    input wire logic [1:0] speedCode,
    input wire logic fullDuplex,
    input wire logic linkUp,
    input wire logic txActive,
    input wire logic rxActive,
    input wire logic collision,
    input wire logic anBothEnabled,
    input wire logic partnerPause,
    input wire logic partnerAsymPause,
    input wire logic ledConfigStrap,
    // LED functions from mode selection, on mclk.
    input wire logic ledFuncLinkActivity,
    input wire logic ledFuncGigabit,
    input wire logic ledFuncHundred,
    input wire logic ledFuncTen,
    // Link control outputs.
    output logic linkStandby,
    output logic anRestart,
    // LED outputs and settings.
    output logic ledLinkActivity,
    output logic ledGigabit,
    output logic ledHundred,
    output logic ledTen,
    output logic [3:0] ledExtendedMode,
    output logic [3:0] ledBlinkPause
);

    // ================================================================
    // Address decode, shared by the write and read paths.
    function automatic psl_pkg::psl_reg_sel_t regSel(
        input logic [`PSL_ADDR_MSB:0] addr
    );
        logic [7:0] idx;
        idx = addr[`PSL_IDX_MSB:`PSL_IDX_LSB];
        regSel = psl_pkg::PSL_SEL_NONE;
        if (addr[`PSL_ADDR_MSB:`PSL_IDX_MSB+1] == '0) begin
            if (idx == `PSL_IDX_LINK_CTL) begin
                regSel = psl_pkg::PSL_SEL_LINK;
            end else if (idx == `PSL_IDX_STATUS) begin
                regSel = psl_pkg::PSL_SEL_STATUS;
            end else if (idx == `PSL_IDX_LED_CTL) begin
                regSel = psl_pkg::PSL_SEL_LED;
            end
        end
    endfunction

    // Two-colour pairing: the first LED wins a conflict, so the pair
    // never shows both colours and the board needs no extra logic.
    function automatic logic [1:0] pairLeds(
        input logic first,
        input logic second,
        input logic twoColour
    );
        pairLeds = twoColour ? {first, second & ~first} : {first, second};
    endfunction

    // ================================================================
    // Storage.
    logic linkEnableCtl;
    logic [15:0] ledCtl;
    logic [14:0] statusSync;
    logic strapSync;
    logic [2:0] strapWait;
    psl_pkg::psl_link_state_t linkState;
    psl_pkg::psl_link_state_t next_linkState;
    logic awHeld;
    logic wHeld;
    logic [`PSL_ADDR_MSB:0] awAddrQ;
    logic [31:0] wDataQ;
    logic [3:0] wStrbQ;

    // ================================================================
    // Status inputs pass the three-stage filter.
    psl_sync3 #(
        .WIDTH(15),
        .RST_VAL(`PSL_STATUS_RST)
    ) u_statusSync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .asyncIn({anFaultCode, anComplete, pairSwapped, polarityInverted,
            speedCode, fullDuplex, linkUp, txActive, rxActive, collision,
            anBothEnabled, partnerPause, partnerAsymPause}),
        .syncOut(statusSync)
    );

    psl_sync3 #(
        .WIDTH(1),
        .RST_VAL(1'h0)
    ) u_strapSync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .asyncIn(ledConfigStrap),
        .syncOut(strapSync)
    );

    // ================================================================
    // Write channel handshakes and decode.
    wire awFire = awvalid & awready;
    wire wFire = wvalid & wready;
    wire awHave = awHeld | awFire;
    wire wHave = wHeld | wFire;
    wire doWrite = awHave & wHave & ~bvalid;
    wire next_awHeld = awHave & ~doWrite;
    wire next_wHeld = wHave & ~doWrite;
    wire next_bvalid = doWrite | (bvalid & ~bready);
    wire [`PSL_ADDR_MSB:0] wrAddr = awFire ? awaddr : awAddrQ;
    wire [31:0] wrData = wFire ? wdata : wDataQ;
    wire [3:0] wrStrb = wFire ? wstrb : wStrbQ;
    wire psl_pkg::psl_reg_sel_t wrSel = regSel(wrAddr);
    wire wrLink = doWrite & (wrSel == psl_pkg::PSL_SEL_LINK);
    wire wrLed = doWrite & (wrSel == psl_pkg::PSL_SEL_LED);
    wire wrMapped = wrSel != psl_pkg::PSL_SEL_NONE;

    // Write channel state; awready and wready drop while a word waits
    // or a response is pending, so one write is in flight at a time.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            awHeld <= 1'h0;
            wHeld <= 1'h0;
            awready <= 1'h0;
            wready <= 1'h0;
            bvalid <= 1'h0;
            bresp <= `PSL_RESP_OKAY;
        end else begin
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awready <= ~next_awHeld & ~next_bvalid;
            wready <= ~next_wHeld & ~next_bvalid;
            bvalid <= next_bvalid;
            if (doWrite) begin
                bresp <= wrMapped ? `PSL_RESP_OKAY : `PSL_RESP_DECERR;
            end
        end
    end

    // Latched write address and data.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            awAddrQ <= '0;
            wDataQ <= '0;
            wStrbQ <= '0;
        end else begin
            if (awFire) begin
                awAddrQ <= awaddr;
            end
            if (wFire) begin
                wDataQ <= wdata;
                wStrbQ <= wstrb;
            end
        end
    end

    // ================================================================
    // Control registers. A status write falls through unstored. R20
    wire strapLoad = strapWait == `PSL_STRAP_WAIT - 3'h1;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            linkEnableCtl <= `PSL_LINK_EN_RST;
            ledCtl <= '0; // R19
            strapWait <= '0;
        end else begin
            if (strapWait != `PSL_STRAP_WAIT) begin
                strapWait <= strapWait + 3'h1;
            end
            // The strap is caught once the filter has settled. R18
            if (strapLoad) begin
                ledCtl[`PSL_EXT_TEN_BIT] <= strapSync; // R18
            end
            if (wrLink && wrStrb[1]) begin
                linkEnableCtl <= wrData[`PSL_LINK_EN_BIT];
            end
            if (wrLed && wrStrb[0]) begin
                ledCtl[`PSL_BLINK_MSB:`PSL_BLINK_LSB] <=
                    wrData[`PSL_BLINK_MSB:`PSL_BLINK_LSB]; // R19
            end
            if (wrLed && wrStrb[1]) begin
                ledCtl[`PSL_TWO_CD_BIT:`PSL_EXT_LSB] <=
                    wrData[`PSL_TWO_CD_BIT:`PSL_EXT_LSB]; // R17
            end
        end
    end

    // ================================================================
    // Link state: standby follows link enable, and leaving standby
    // starts a fresh negotiation.
    always_comb begin
        next_linkState = linkState;
        case (linkState)
            psl_pkg::PSL_LINK_STANDBY: begin
                if (linkEnableCtl) begin
                    next_linkState = psl_pkg::PSL_LINK_NEGOTIATE; // R2
                end
            end
            psl_pkg::PSL_LINK_NEGOTIATE: begin
                if (statusSync[12]) begin
                    next_linkState = psl_pkg::PSL_LINK_UP;
                end
            end
            psl_pkg::PSL_LINK_UP: begin
                if (!statusSync[12]) begin
                    next_linkState = psl_pkg::PSL_LINK_NEGOTIATE;
                end
            end
            default: begin
                next_linkState = psl_pkg::PSL_LINK_STANDBY;
            end
        endcase
        if (!linkEnableCtl) begin
            next_linkState = psl_pkg::PSL_LINK_STANDBY; // R1
        end
    end

    // Link state register with standby flag and restart pulse.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            linkState <= psl_pkg::PSL_LINK_STANDBY;
            linkStandby <= 1'h1;
            anRestart <= 1'h0;
        end else begin
            linkState <= next_linkState;
            linkStandby <= next_linkState == psl_pkg::PSL_LINK_STANDBY; // R1
            anRestart <= (linkState == psl_pkg::PSL_LINK_STANDBY) &&
                (next_linkState == psl_pkg::PSL_LINK_NEGOTIATE); // R2
        end
    end

    // ================================================================
    // Status word: live filtered core signals under the standby flag.
    // R3 R4 R5 R6 R7 R8 R9 R10 R11 R12 R13
    wire [15:0] statusWord = {linkStandby, statusSync};

    // ================================================================
    // Read channel; the answer comes one cycle after the address.
    wire arFire = arvalid & arready;
    wire next_rvalid = arFire | (rvalid & ~rready);
    wire psl_pkg::psl_reg_sel_t rdSel = regSel(araddr);
    wire [15:0] linkWord = 16'(linkEnableCtl) << `PSL_LINK_EN_BIT;
    // Reserved bits 9:8 and the lower bits held elsewhere read zero.
    wire [15:0] ledWord = {ledCtl[`PSL_TWO_CD_BIT:`PSL_EXT_LSB], 2'h0,
        ledCtl[`PSL_BLINK_MSB:`PSL_BLINK_LSB], 4'h0};
    wire [15:0] rdWord =
        (rdSel == psl_pkg::PSL_SEL_LINK) ? linkWord :
        (rdSel == psl_pkg::PSL_SEL_STATUS) ? statusWord :
        (rdSel == psl_pkg::PSL_SEL_LED) ? ledWord : 16'h0000;

    // Read channel registers.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            arready <= 1'h0;
            rvalid <= 1'h0;
            rdata <= '0;
            rresp <= `PSL_RESP_OKAY;
        end else begin
            arready <= ~next_rvalid;
            rvalid <= next_rvalid;
            if (arFire) begin
                rdata <= {16'h0000, rdWord};
                rresp <= (rdSel == psl_pkg::PSL_SEL_NONE) ?
                    `PSL_RESP_DECERR : `PSL_RESP_OKAY;
            end
        end
    end

    // ================================================================
    // LED outputs with optional two-colour pairing.
    wire [1:0] pairAb = pairLeds(ledFuncLinkActivity, ledFuncGigabit,
        ledCtl[`PSL_TWO_AB_BIT]); // R14 R15
    wire [1:0] pairCd = pairLeds(ledFuncHundred, ledFuncTen,
        ledCtl[`PSL_TWO_CD_BIT]); // R16 R15

    // LED output registers keep the outputs glitch free.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ledLinkActivity <= 1'h0;
            ledGigabit <= 1'h0;
            ledHundred <= 1'h0;
            ledTen <= 1'h0;
        end else begin
            ledLinkActivity <= pairAb[1];
            ledGigabit <= pairAb[0];
            ledHundred <= pairCd[1];
            ledTen <= pairCd[0];
        end
    end

    // Mode settings handed to the LED function selection.
    assign ledExtendedMode = ledCtl[`PSL_EXT_MSB:`PSL_EXT_LSB]; // R17
    assign ledBlinkPause = ledCtl[`PSL_BLINK_MSB:`PSL_BLINK_LSB];

    // ================================================================
    // Checks.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    standby_entry_a: assert property ($fell(linkEnableCtl) |=> linkStandby) // R1
        else $error("Standby not entered after link enable cleared.");
    standby_exit_a: assert property ( // R2
        $rose(linkEnableCtl) |=> !linkStandby && anRestart ##1 !anRestart)
        else $error("Standby exit did not restart negotiation once.");
    status_reset_a: assert property ( // R7
        $fell(sys_rst) |-> statusWord[`PSL_SPEED_MSB:`PSL_SPEED_LSB] == 2'h3
            && statusWord[`PSL_POL_BIT])
        else $error("Speed or polarity reset value wrong.");
    status_track_a: assert property ( // R8
        $rose(txActive) ##1 txActive [*4] |-> statusWord[5])
        else $error("Transmit status did not follow the core.");
    pair_exclusive_a: assert property ( // R15
        $past(ledCtl[`PSL_TWO_AB_BIT]) |-> !(ledLinkActivity && ledGigabit))
        else $error("Both LEDs of a two-colour pair lit.");
    blink_reset_a: assert property ($fell(sys_rst) |-> ledBlinkPause == 4'h0) // R19
        else $error("Blink pause field not zero after reset.");
    ro_write_a: assert property ( // R20
        doWrite && wrSel == psl_pkg::PSL_SEL_STATUS |=> $stable(ledCtl)
            && $stable(linkEnableCtl))
        else $error("Status write changed a control register.");
    write_answer_a: assert property (doWrite |=> bvalid [*1] ##0 !awready)
        else $error("Write response missing after write.");
    read_answer_a: assert property (arFire |=> rvalid && !arready)
        else $error("Read data missing one cycle after address.");

    write_seen_c: cover property (doWrite && wrLed);
    read_status_c: cover property (arFire && rdSel == psl_pkg::PSL_SEL_STATUS);
    pair_conflict_c: cover property (ledCtl[`PSL_TWO_AB_BIT]
        && ledFuncLinkActivity && ledFuncGigabit);
    standby_seen_c: cover property ($rose(linkStandby));

endmodule

// ---- hw/psl_sync3.sv ----
// Three-stage input synchroniser with agreement filter.
// Assumes inputs come from outside the mclk domain.
`timescale 1ns/1ps
module psl_sync3 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic sys_rst,
    // Asynchronous input and filtered result.
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    // ================================================================
    // Per-bit chains.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic stage1;
            logic stage2;
            logic stage3;
            // The first stage feeds only the second, so a metastable
            // value never reaches the comparison.
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    stage1 <= RST_VAL[i];
                    stage2 <= RST_VAL[i];
                    stage3 <= RST_VAL[i];
                    syncOut[i] <= RST_VAL[i];
                end else begin
                    stage1 <= asyncIn[i];
                    stage2 <= stage1;
                    stage3 <= stage2;
                    if (stage2 == stage3) begin
                        syncOut[i] <= stage3;
                    end
                end
            end
        end
    endgenerate

endmodule

// ---- tb/phy_status_led_control_regs_bench.sv ----
// Self-checking bench for the status and LED control register block.
// Assumes the design files and the core model are compiled first.
`timescale 1ns/1ps
`include "psl_defines.svh"
module phy_status_led_control_regs_bench;
    // ================================================================
    // Addresses and signals.
    localparam logic [11:0] A_LINK = 12'(`PSL_IDX_LINK_CTL) << 2;
    localparam logic [11:0] A_STAT = 12'(`PSL_IDX_STATUS) << 2;
    localparam logic [11:0] A_LED = 12'(`PSL_IDX_LED_CTL) << 2;
    logic mclk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, strap, linkStandby, anRestart;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb, coreFunc, ledFunc, ledExtendedMode;
    wire [3:0] leds;
    logic [3:0] ledBlinkPause;
    logic [1:0] bresp, rresp, resp, fault, speed;
    logic [14:0] coreStatus;
    logic anDone, swap, pol, dup, lnk, tx, rx, col, anBoth, pp, pa, cfg;
    int failCount, checked, cycles, restartCount;

    psl_core_model core_u (.coreStatus(coreStatus), .coreFunc(coreFunc),
        .strapLevel(strap), .anFaultCode(fault), .anComplete(anDone),
        .pairSwapped(swap), .polarityInverted(pol), .speedCode(speed),
        .fullDuplex(dup), .linkUp(lnk), .txActive(tx), .rxActive(rx),
        .collision(col), .anBothEnabled(anBoth), .partnerPause(pp),
        .partnerAsymPause(pa), .ledConfigStrap(cfg), .ledFunc(ledFunc));

    psl_status_regs dut_u (.mclk(mclk), .sys_rst(sys_rst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .anFaultCode(fault),
        .anComplete(anDone), .pairSwapped(swap), .polarityInverted(pol),
        .speedCode(speed), .fullDuplex(dup), .linkUp(lnk), .txActive(tx),
        .rxActive(rx), .collision(col), .anBothEnabled(anBoth),
        .partnerPause(pp), .partnerAsymPause(pa), .ledConfigStrap(cfg),
        .ledFuncLinkActivity(ledFunc[3]), .ledFuncGigabit(ledFunc[2]),
        .ledFuncHundred(ledFunc[1]), .ledFuncTen(ledFunc[0]),
        .linkStandby(linkStandby), .anRestart(anRestart),
        .ledLinkActivity(leds[3]), .ledGigabit(leds[2]),
        .ledHundred(leds[1]), .ledTen(leds[0]),
        .ledExtendedMode(ledExtendedMode), .ledBlinkPause(ledBlinkPause));

    // ================================================================
    // Clock, restart pulse counter and hang guard.
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // A cut-off well above the few hundred cycles the tests need.
    always @(posedge mclk) begin
        cycles++;
        if (!sys_rst && anRestart === 1'b1) begin
            restartCount++;
        end
        if (cycles == 5000) begin
            failCount++;
            closeOut();
        end
    end

    // ================================================================
    // Comparison, verdict and bus tasks.
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic closeOut();
        if (failCount == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Address and data go out together; each drops once it is taken.
    task automatic axiWrite(input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [1:0] r);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axiRead(input logic [11:0] a, output logic [31:0] d,
            output logic [1:0] r);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    // ================================================================
    // Test sequence.
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = '0;
        // The core reports all zero, so only the filter's reset value
        // can show speed 11 and polarity 1 on the first, early read.
        coreStatus = 15'h0000;
        coreFunc = 4'hF;
        strap = 1'b1;
        sys_rst = 1'b1;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        axiRead(A_STAT, rd, resp);
        check("status reset", rd, 32'h00000700);
        check("status read resp", resp, `PSL_RESP_OKAY);
        check("restart after reset", restartCount, 32'h1);
        // Control reset values once the strap filter has settled.
        repeat (10) @(posedge mclk);
        axiRead(A_LED, rd, resp);
        check("led ctl reset", rd, 32'h00002000);
        axiRead(A_LINK, rd, resp);
        check("link ctl reset", rd, 32'h00002000);
        check("link read resp", resp, `PSL_RESP_OKAY);
        // Walk a single one through every live status bit.
        for (int i = 0; i < 15; i++) begin
            coreStatus <= 15'h0001 << i;
            repeat (8) @(posedge mclk);
            axiRead(A_STAT, rd, resp);
            check("status walk", rd, 32'h1 << i);
        end
        // Set bits 10 to 8 again, then check that a status write is ignored.
        coreStatus <= 15'h0700;
        repeat (8) @(posedge mclk);
        axiWrite(A_STAT, 32'h0000FFFF, 4'hF, resp);
        check("status write resp", resp, `PSL_RESP_OKAY);
        axiRead(A_STAT, rd, resp);
        check("status after write", rd, 32'h00000700);
        // Unmapped place answers with a decode error both ways.
        axiWrite(12'h000, 32'h0000FFFF, 4'hF, resp);
        check("unmapped write", resp, `PSL_RESP_DECERR);
        axiRead(12'h000, rd, resp);
        check("unmapped read", resp, `PSL_RESP_DECERR);
        // Standby entry and exit through link enable.
        axiWrite(A_LINK, 32'h00000000, 4'hF, resp);
        repeat (3) @(posedge mclk);
        check("standby level", linkStandby, 1'b1);
        axiRead(A_STAT, rd, resp);
        check("status standby", rd, 32'h00008700);
        axiWrite(A_LINK, 32'h00002000, 4'hF, resp);
        repeat (3) @(posedge mclk);
        check("standby left", linkStandby, 1'b0);
        check("restart pulse", restartCount, 32'h2);
        axiRead(A_STAT, rd, resp);
        check("status active", rd, 32'h00000700);
        // Control word fields, reserved bits and byte strobes.
        axiWrite(A_LED, 32'h0000FFFF, 4'hF, resp);
        axiRead(A_LED, rd, resp);
        check("led ctl all", rd, 32'h0000FCF0);
        check("extended modes", ledExtendedMode, 4'hF);
        check("blink pause", ledBlinkPause, 4'hF);
        axiWrite(A_LED, 32'h00000000, 4'h2, resp);
        axiRead(A_LED, rd, resp);
        check("led ctl high byte", rd, 32'h000000F0);
        // Normal, paired and partly lit LED functions.
        axiWrite(A_LED, 32'h00000000, 4'hF, resp);
        repeat (3) @(posedge mclk);
        check("leds normal", leds, 4'hF);
        axiWrite(A_LED, 32'h0000C000, 4'hF, resp);
        repeat (3) @(posedge mclk);
        check("leds paired", leds, 4'hA);
        coreFunc <= 4'h5;
        repeat (3) @(posedge mclk);
        check("leds second only", leds, 4'h5);
        closeOut();
    end
endmodule

// ---- tb/psl_core_model.sv ----
// Behavioural model of the transceiver core behind the register block.
// Assumes the bench sets the status and LED function levels on mclk.
`timescale 1ns/1ps
module psl_core_model (
    // Levels requested by the bench.
    input wire logic [14:0] coreStatus,
    input wire logic [3:0] coreFunc,
    input wire logic strapLevel,
    // Status lines toward the register block.
    output logic [1:0] anFaultCode,
    output logic anComplete,
    output logic pairSwapped,
    output logic polarityInverted,
    output logic [1:0] speedCode,
    output logic fullDuplex,
    output logic linkUp,
    output logic txActive,
    output logic rxActive,
    output logic collision,
    output logic anBothEnabled,
    output logic partnerPause,
    output logic partnerAsymPause,
    output logic ledConfigStrap,
    // LED functions, link/activity first and ten last.
    output logic [3:0] ledFunc
);
    // ================================================================
    // Status lines follow the requested word bit for bit.
    assign {anFaultCode, anComplete, pairSwapped, polarityInverted} =
        coreStatus[14:10];
    assign {speedCode, fullDuplex, linkUp, txActive, rxActive} =
        coreStatus[9:4];
    assign {collision, anBothEnabled, partnerPause, partnerAsymPause} =
        coreStatus[3:0];
    // The strap is a static level, so it never changes after reset.
    assign ledConfigStrap = strapLevel;
    assign ledFunc = coreFunc;
endmodule
